// file: pkg/cas_defines.svh
// constants for the architectural state registers
`ifndef CAS_DEFINES_SVH
`define CAS_DEFINES_SVH
`define CAS_CODE_SEG_RESET 16'hFFFF
`define CAS_SEG_RESET      16'h0000
`define CAS_IP_RESET       16'h0000
`define CAS_FLAGS_RESET    16'h0000
`define CAS_FLAGS_MASK     16'h0FD5
`define CAS_OF 11
`define CAS_DF 10
`define CAS_IF 9
`define CAS_TF 8
`define CAS_SF 7
`define CAS_ZF 6
`define CAS_AF 4
`define CAS_PF 2
`define CAS_CF 0
`define CAS_GPR_BASE   8'h00
`define CAS_SEG_BASE   8'h20
`define CAS_FLAGS_ADDR 8'h30
`define CAS_ACC   3'h0
`define CAS_COUNT 3'h1
`define CAS_IOPRT 3'h2
`define CAS_STACK 3'h4
`define CAS_SRC   3'h6
`define CAS_DEST  3'h7
`endif

// file: pkg/cas_pkg.sv
// types shared by the architectural state registers
package cas_pkg;
    typedef enum logic [1:0] {CAS_WR_WORD, CAS_WR_LOW, CAS_WR_HIGH} cas_wrmode_e;
    typedef enum logic [1:0] {CAS_SEG_CODE, CAS_SEG_DATA, CAS_SEG_STACK, CAS_SEG_EXTRA} cas_seg_e;
    typedef enum logic [1:0] {CAS_AG_FETCH, CAS_AG_STACK, CAS_AG_DATA, CAS_AG_EXTRA} cas_agen_e;
    typedef logic [15:0] cas_word_t;
endpackage

// file: design/cas_arch_regs.sv
// architectural register state, flags and address generation
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "cas_defines.svh"

// Notes on behaviour
// RULE1 - eight word registers; the four data registers also written as byte halves
// RULE2 - accumulator and io port register exported for multiply, divide and port I/O
// RULE3 - count, shift count byte, stack pointer and index registers exported for their uses
// RULE4 - four segment bases; fetch uses code, stack uses stack, data uses data/extra
// RULE5 - reset loads code segment with all ones
// RULE6 - reset clears data, stack and extra segments
// RULE7 - instruction pointer not software visible; loaded or advanced by the bus unit
// RULE8 - reset clears instruction pointer, so first fetch is at FFFF0
// RULE9 - flags word resets to zero, updated after each operation at fixed bits
// RULE10 - overflow flag follows signed overflow of arithmetic
// RULE11 - direction flag set/cleared by instructions; set steps up, clear steps down
// RULE12 - interrupt enable flag gates maskable requests
// RULE13 - trace flag set gives a debug trap after each following instruction
// RULE14 - sign flag copies result top bit
// RULE15 - zero flag set exactly when result is zero
// RULE16 - aux carry flag follows low nibble carry or borrow
// RULE17 - parity flag set on even ones in low byte
// RULE18 - carry flag follows carry out of or borrow into top bit
// RULE19 - 20-bit physical address formed and handed to the bus unit
// RULE20 - physical address is segment shifted by four plus offset, wrapped
// RULE21 - reserved flag bits read zero and ignore writes
module cas_arch_regs
    import cas_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // general register write port
    input  wire logic        gprWrEn,
    input  wire logic [2:0]  gprWrSel,
    input  cas_wrmode_e      gprWrMode,
    input  wire cas_word_t   gprWrData,
    // segment write port
    input  wire logic        segWrEn,
    input  cas_seg_e         segWrSel,
    input  wire cas_word_t   segWrData,
    // string index stepping
    input  wire logic        strStep,
    input  wire logic        strStepWord,
    // instruction pointer control
    input  wire logic        ipLoad,
    input  wire cas_word_t   ipLoadValue,
    input  wire logic        ipAdvance,
    input  wire logic [3:0]  ipAdvanceBy,
    // flag updates
    input  wire logic        aluValid,
    input  wire logic        aluByte,
    input  wire cas_word_t   aluResult,
    input  wire logic        aluCarry,
    input  wire logic        aluOverflow,
    input  wire logic        aluAux,
    input  wire logic        aluKeepCarry,
    input  wire logic        dirSet,
    input  wire logic        dirClr,
    input  wire logic        intSet,
    input  wire logic        intClr,
    input  wire logic        flagsLoad,
    input  wire cas_word_t   flagsLoadValue,
    input  wire logic        instrDone,
    input  wire logic        maskIntReq,
    // address generation
    input  wire logic        agenReq,
    input  cas_agen_e        agenKind,
    input  wire cas_word_t   agenOffset,
    // implicit register outputs
    output cas_word_t        accumulatorWord,
    output cas_word_t        ioPortReg,
    output cas_word_t        countReg,
    output logic      [7:0]  shiftCountByte,
    output cas_word_t        stackPointer,
    output cas_word_t        srcIndex,
    output cas_word_t        destIndex,
    output cas_word_t        instructionPointer,
    output cas_word_t        processorStatusFlags,
    // control outputs
    output logic             stringStepUp,
    output logic             intAccept,
    output logic             debugTrap,
    output logic      [19:0] physAddr,
    output logic             physAddrValid
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    cas_word_t   gpr [8];
    cas_word_t   seg [4];
    cas_word_t   next_gpr [8];
    cas_word_t   next_seg [4];
    cas_word_t   ip;
    cas_word_t   next_ip;
    cas_word_t   flags;
    cas_word_t   next_flags;
    logic [19:0] next_physAddr;
    logic        next_physAddrValid;
    logic        next_debugTrap;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        apbSetup;
    logic        apbWrite;
    logic [15:0] idxStep;

    // decode: returns 1 when the address hits a mapped register
    function automatic logic addrMapped(input logic [7:0] a);
        addrMapped = (a[1:0] == 2'h0) &&
                     ((a < `CAS_SEG_BASE) || (a < `CAS_FLAGS_ADDR) || (a == `CAS_FLAGS_ADDR));
    endfunction

    function automatic logic evenParity(input logic [7:0] b);
        evenParity = ~(^b);
    endfunction

    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pready & pwrite & ~pslverr;
    // data is prepared in the setup cycle, so every access is zero wait
    assign pready   = 1'b1;

    // ----------------------------------------------------------------
    // general and segment registers
    // ----------------------------------------------------------------
    // core writes take priority over software writes to the same word
    always_comb begin
        next_gpr = gpr;
        next_seg = seg;
        idxStep  = strStepWord ? 16'h0002 : 16'h0001;
        if (apbWrite && paddr < `CAS_SEG_BASE) begin
            next_gpr[paddr[4:2]] = pwdata[15:0];
        end
        if (apbWrite && paddr >= `CAS_SEG_BASE && paddr < `CAS_FLAGS_ADDR) begin
            next_seg[paddr[3:2]] = pwdata[15:0];
        end
        if (strStep) begin
            if (flags[`CAS_DF]) begin                                  // RULE11
                next_gpr[`CAS_SRC]  = gpr[`CAS_SRC] + idxStep;         // RULE3
                next_gpr[`CAS_DEST] = gpr[`CAS_DEST] + idxStep;
            end else begin
                next_gpr[`CAS_SRC]  = gpr[`CAS_SRC] - idxStep;
                next_gpr[`CAS_DEST] = gpr[`CAS_DEST] - idxStep;
            end
        end
        if (gprWrEn) begin
            // byte halves only exist on the four data registers
            if (gprWrMode == CAS_WR_LOW && !gprWrSel[2]) begin
                next_gpr[gprWrSel][7:0] = gprWrData[7:0];              // RULE1
            end else if (gprWrMode == CAS_WR_HIGH && !gprWrSel[2]) begin
                next_gpr[gprWrSel][15:8] = gprWrData[7:0];
            end else begin
                next_gpr[gprWrSel] = gprWrData;
            end
        end
        if (segWrEn) begin
            next_seg[segWrSel] = segWrData;                            // RULE4
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                gpr[i] <= 16'h0000;
            end
            seg[CAS_SEG_CODE]  <= `CAS_CODE_SEG_RESET;                 // RULE5
            seg[CAS_SEG_DATA]  <= `CAS_SEG_RESET;                      // RULE6
            seg[CAS_SEG_STACK] <= `CAS_SEG_RESET;
            seg[CAS_SEG_EXTRA] <= `CAS_SEG_RESET;
        end else begin
            gpr <= next_gpr;
            seg <= next_seg;
        end
    end

    // implicit operands
    assign accumulatorWord = gpr[`CAS_ACC];                            // RULE2
    assign ioPortReg       = gpr[`CAS_IOPRT];
    assign countReg        = gpr[`CAS_COUNT];                          // RULE3
    assign shiftCountByte  = gpr[`CAS_COUNT][7:0];
    assign stackPointer    = gpr[`CAS_STACK];
    assign srcIndex        = gpr[`CAS_SRC];
    assign destIndex       = gpr[`CAS_DEST];

    // ----------------------------------------------------------------
    // instruction pointer
    // ----------------------------------------------------------------
    // no software path: only the bus unit and flow changes touch it
    always_comb begin
        next_ip = ip;
        if (ipLoad) begin
            next_ip = ipLoadValue;                                     // RULE7
        end else if (ipAdvance) begin
            next_ip = ip + {12'h000, ipAdvanceBy};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ip <= `CAS_IP_RESET;                                       // RULE8
        end else begin
            ip <= next_ip;
        end
    end

    assign instructionPointer = ip;

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // later sources win: software, result, set/clear, then whole-word pop
    always_comb begin
        next_flags = flags;
        if (apbWrite && paddr == `CAS_FLAGS_ADDR) begin
            next_flags = pwdata[15:0];
        end
        if (aluValid) begin                                            // RULE9
            next_flags[`CAS_OF] = aluOverflow;                         // RULE10
            next_flags[`CAS_SF] = aluByte ? aluResult[7] : aluResult[15]; // RULE14
            next_flags[`CAS_ZF] = aluByte ? (aluResult[7:0] == 8'h00)
                                          : (aluResult == 16'h0000);   // RULE15
            next_flags[`CAS_AF] = aluAux;                              // RULE16
            next_flags[`CAS_PF] = evenParity(aluResult[7:0]);          // RULE17
            if (!aluKeepCarry) begin
                next_flags[`CAS_CF] = aluCarry;                        // RULE18
            end
        end
        if (dirSet) begin
            next_flags[`CAS_DF] = 1'b1;                                // RULE11
        end else if (dirClr) begin
            next_flags[`CAS_DF] = 1'b0;
        end
        if (intSet) begin
            next_flags[`CAS_IF] = 1'b1;                                // RULE12
        end else if (intClr) begin
            next_flags[`CAS_IF] = 1'b0;
        end
        if (flagsLoad) begin
            next_flags = flagsLoadValue;
        end
        next_flags = next_flags & `CAS_FLAGS_MASK;                     // RULE21
        // trap sees the old trace bit, so the loading instruction itself is spared
        next_debugTrap = instrDone & flags[`CAS_TF];                   // RULE13
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags     <= `CAS_FLAGS_RESET;                             // RULE9
            debugTrap <= 1'b0;
        end else begin
            flags     <= next_flags;
            debugTrap <= next_debugTrap;
        end
    end

    assign processorStatusFlags = flags;
    assign stringStepUp = flags[`CAS_DF];                              // RULE11
    assign intAccept    = maskIntReq & flags[`CAS_IF];                 // RULE12

    // ----------------------------------------------------------------
    // address generation
    // ----------------------------------------------------------------
    // carry past bit 19 wraps, matching a 1 MB space
    always_comb begin
        unique case (agenKind)
            CAS_AG_FETCH: next_physAddr = {seg[CAS_SEG_CODE], 4'h0} + {4'h0, ip};   // RULE4
            CAS_AG_STACK: next_physAddr = {seg[CAS_SEG_STACK], 4'h0} + {4'h0, agenOffset};
            CAS_AG_DATA:  next_physAddr = {seg[CAS_SEG_DATA], 4'h0} + {4'h0, agenOffset};
            CAS_AG_EXTRA: next_physAddr = {seg[CAS_SEG_EXTRA], 4'h0} + {4'h0, agenOffset};
        endcase
        if (!agenReq) begin
            next_physAddr = physAddr;
        end
        next_physAddrValid = agenReq;                                  // RULE19
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            physAddr      <= 20'h00000;
            physAddrValid <= 1'b0;
        end else begin
            physAddr      <= next_physAddr;                            // RULE20
            physAddrValid <= next_physAddrValid;
        end
    end

    // ----------------------------------------------------------------
    // apb read path
    // ----------------------------------------------------------------
    // read data captured in setup so the access phase needs no wait
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (apbSetup) begin
            next_pslverr = ~addrMapped(paddr);
            next_prdata  = 32'h00000000;
            if (paddr < `CAS_SEG_BASE) begin
                next_prdata[15:0] = gpr[paddr[4:2]];
            end else if (paddr < `CAS_FLAGS_ADDR) begin
                next_prdata[15:0] = seg[paddr[3:2]];
            end else if (paddr == `CAS_FLAGS_ADDR) begin
                next_prdata[15:0] = flags;
            end
            if (pwrite || !addrMapped(paddr)) begin
                next_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [19:0] expAddr;
    assign expAddr = {seg[CAS_SEG_DATA], 4'h0} + {4'h0, agenOffset};

    code_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> (seg[CAS_SEG_CODE] == `CAS_CODE_SEG_RESET && ip == `CAS_IP_RESET)) // RULE5
        else $error("code segment or pointer not at reset value");
    seg_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> (seg[CAS_SEG_STACK] == `CAS_SEG_RESET && flags == `CAS_FLAGS_RESET)) // RULE6
        else $error("stack segment or flags not cleared");
    reserved_zero_a: assert property ((flags & ~`CAS_FLAGS_MASK) == 16'h0000) // RULE21
        else $error("reserved flag bit set");
    data_addr_a: assert property (agenReq && agenKind == CAS_AG_DATA
        |=> physAddrValid && physAddr == $past(expAddr)) // RULE20
        else $error("data physical address wrong");
    zero_flag_a: assert property (aluValid && !aluByte && aluResult == 16'h0000
        && !flagsLoad && !apbWrite |=> flags[`CAS_ZF]) // RULE15
        else $error("zero flag not set on zero result");
    parity_flag_a: assert property (aluValid && !flagsLoad
        |=> flags[`CAS_PF] == ~(^$past(aluResult[7:0]))) // RULE17
        else $error("parity flag wrong");
    int_gate_a: assert property (intClr && !intSet && !flagsLoad
        |=> !intAccept) // RULE12
        else $error("interrupt accepted while disabled");
    trace_trap_a: assert property (instrDone && flags[`CAS_TF]
        |=> debugTrap ##1 (debugTrap == $past(instrDone && flags[`CAS_TF]))) // RULE13
        else $error("trace trap missing");
    dir_step_a: assert property (dirSet && !flagsLoad
        |=> stringStepUp) // RULE11
        else $error("direction flag not set");
    low_byte_a: assert property (gprWrEn && gprWrMode == CAS_WR_LOW && gprWrSel == `CAS_ACC
        |=> accumulatorWord[15:8] == $past(accumulatorWord[15:8])) // RULE1
        else $error("low byte write disturbed high byte");

    fetch_c:  cover property (agenReq && agenKind == CAS_AG_FETCH ##1 physAddrValid);
    trap_c:   cover property (flagsLoad && flagsLoadValue[`CAS_TF] ##[1:4] debugTrap);
    apbwr_c:  cover property (apbWrite && paddr == `CAS_FLAGS_ADDR);

endmodule // cas_arch_regs

// file: testbench/cas_biu_model.sv
// behavioural bus interface unit: asks for addresses and steps the pointer
`timescale 1ns/100ps
module cas_biu_model
    import cas_pkg::*;
#(
    parameter logic [3:0] ADV = 4'h2
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // commands from the bench
    input  wire logic        reqGo,
    input  cas_agen_e        reqKind,
    input  wire cas_word_t   reqOffset,
    input  wire logic        jmpGo,
    input  wire cas_word_t   jmpTarget,
    // execution unit side
    output logic             agenReq,
    output cas_agen_e        agenKind,
    output cas_word_t        agenOffset,
    output logic             ipLoad,
    output cas_word_t        ipLoadValue,
    output logic             ipAdvance,
    output logic      [3:0]  ipAdvanceBy,
    input  wire logic [19:0] physAddr,
    input  wire logic        physAddrValid,
    // result for the bench
    output logic      [19:0] lastAddr,
    output logic             addrSeen
);
    // idle data lines toggle, so a stale value never passes for a fresh one
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            agenReq     <= 1'b0;
            agenKind    <= CAS_AG_FETCH;
            agenOffset  <= 16'h0000;
            ipLoad      <= 1'b0;
            ipLoadValue <= 16'h0000;
            ipAdvance   <= 1'b0;
            ipAdvanceBy <= ADV;
            lastAddr    <= 20'h00000;
            addrSeen    <= 1'b0;
        end else begin
            agenReq     <= reqGo;
            agenKind    <= reqKind;
            agenOffset  <= reqGo ? reqOffset : ~agenOffset;
            ipLoad      <= jmpGo;
            ipLoadValue <= jmpGo ? jmpTarget : ~ipLoadValue;
            // step the pointer once the fetch request is taken
            ipAdvance   <= agenReq && (agenKind == CAS_AG_FETCH);
            if (physAddrValid) begin
                lastAddr <= physAddr;
                addrSeen <= 1'b1;
            end else if (reqGo) begin
                addrSeen <= 1'b0;
            end
        end
    end
endmodule // cas_biu_model

// file: testbench/cas_arch_regs_test.sv
// self-checking bench for the architectural state registers
`timescale 1ns/100ps
`include "cas_defines.svh"
module cas_arch_regs_test
    import cas_pkg::*;
;
    localparam logic [3:0] ADV = 4'h2;
    localparam int LIMIT = 4000;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, gprWrEn = 1'b0, segWrEn = 1'b0, strStep = 1'b0;
    logic strStepWord = 1'b0, aluValid = 1'b0, aluByte = 1'b0, aluCarry = 1'b0;
    logic aluOverflow = 1'b0, aluAux = 1'b0, aluKeepCarry = 1'b0, flagsLoad = 1'b0;
    logic dirSet = 1'b0, dirClr = 1'b0, intSet = 1'b0, intClr = 1'b0;
    logic instrDone = 1'b0, maskIntReq = 1'b0, reqGo = 1'b0, jmpGo = 1'b0;
    logic [2:0] gprWrSel = 3'h0;
    cas_wrmode_e gprWrMode = CAS_WR_WORD;
    cas_seg_e segWrSel = CAS_SEG_CODE;
    cas_agen_e reqKind = CAS_AG_FETCH, agenKind;
    cas_word_t gprWrData = 16'h0, segWrData = 16'h0, aluResult = 16'h0;
    cas_word_t flagsLoadValue = 16'h0, reqOffset = 16'h0, jmpTarget = 16'h0, fl = 16'h0;
    cas_word_t ipLoadValue, agenOffset, accumulatorWord, ioPortReg, countReg, stackPointer;
    cas_word_t srcIndex, destIndex, instructionPointer, processorStatusFlags;
    logic ipLoad, ipAdvance, agenReq, stringStepUp, intAccept, debugTrap, physAddrValid;
    logic addrSeen;
    logic [3:0] ipAdvanceBy;
    logic [7:0] shiftCountByte;
    logic [19:0] physAddr, lastAddr;
    int mismatches = 0, nChecks = 0, cycles = 0;

    cas_arch_regs cas_arch_regs_i (.*);
    cas_biu_model #(.ADV(ADV)) cas_biu_model_i (.*);

    // --------------------------------------------
    // clock, timeout and reporting
    // --------------------------------------------
    always #4 ref_clk = ~ref_clk;
    // a hang counts as a failure
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            $display("[ERR] %0t timeout", $time);
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        nChecks++;
        if (got !== exp) begin
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
            mismatches++;
        end
    endtask

    // --------------------------------------------
    // apb master and core strobes
    // --------------------------------------------
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic er_exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp, "read data");
        chk(32'(er), 32'(er_exp), "read response");
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        chk(32'(er), 32'h0, "write response");
    endtask
    task automatic wgpr(input logic [2:0] s, input cas_wrmode_e m, input cas_word_t d);
        gprWrEn   <= 1'b1;
        gprWrSel  <= s;
        gprWrMode <= m;
        gprWrData <= d;
        @(posedge ref_clk);
        gprWrEn   <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic seg(input cas_seg_e s, input cas_word_t d);
        segWrEn   <= 1'b1;
        segWrSel  <= s;
        segWrData <= d;
        @(posedge ref_clk);
        segWrEn   <= 1'b0;
        @(posedge ref_clk);
    endtask
    // expected flags from the operands
    task automatic alu(input logic b, input cas_word_t r, input logic c, o, a, k);
        {aluValid, aluByte, aluResult, aluCarry, aluOverflow, aluAux, aluKeepCarry}
            <= {1'b1, b, r, c, o, a, k};
        @(posedge ref_clk);
        aluValid <= 1'b0;
        @(posedge ref_clk);
        fl[`CAS_OF] = o;
        fl[`CAS_SF] = b ? r[7] : r[15];
        fl[`CAS_ZF] = b ? (r[7:0] == 8'h00) : (r == 16'h0000);
        fl[`CAS_AF] = a;
        fl[`CAS_PF] = ~^r[7:0];
        fl[`CAS_CF] = k ? fl[`CAS_CF] : c;
        chk(32'(processorStatusFlags), 32'(fl), "flags after alu");
    endtask
    task automatic ctl(input logic [3:0] v);
        {dirSet, dirClr, intSet, intClr} <= v;
        @(posedge ref_clk);
        {dirSet, dirClr, intSet, intClr} <= 4'h0;
        @(posedge ref_clk);
    endtask
    task automatic fload(input cas_word_t v, input logic done);
        flagsLoad      <= 1'b1;
        flagsLoadValue <= v;
        instrDone      <= done;
        @(posedge ref_clk);
        flagsLoad      <= 1'b0;
        instrDone      <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic done(input logic exp);
        instrDone <= 1'b1;
        @(posedge ref_clk);
        instrDone <= 1'b0;
        @(posedge ref_clk);
        chk(32'(debugTrap), 32'(exp), "trap after instruction");
    endtask
    task automatic step(input logic w, input cas_word_t s, input cas_word_t d);
        strStep     <= 1'b1;
        strStepWord <= w;
        @(posedge ref_clk);
        strStep     <= 1'b0;
        @(posedge ref_clk);
        chk(32'(srcIndex), 32'(s), "source index step");
        chk(32'(destIndex), 32'(d), "dest index step");
    endtask
    task automatic agen(input cas_agen_e k, input cas_word_t off, input logic [19:0] exp);
        reqGo     <= 1'b1;
        reqKind   <= k;
        reqOffset <= off;
        @(posedge ref_clk);
        reqGo     <= 1'b0;
        @(posedge ref_clk);
        while (addrSeen !== 1'b1) @(posedge ref_clk);
        chk(32'(lastAddr), 32'(exp), "physical address");
    endtask

    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk(32'(instructionPointer), 32'h0, "pointer reset");
        rdchk(`CAS_SEG_BASE, 32'h0000FFFF, 1'b0);
        for (int i = 1; i < 4; i++) rdchk(`CAS_SEG_BASE + 8'(4 * i), 32'h0, 1'b0);
        rdchk(`CAS_FLAGS_ADDR, 32'h0, 1'b0);
        agen(CAS_AG_FETCH, 16'h0000, 20'hFFFF0);
        chk(32'(instructionPointer), 32'(ADV), "pointer after fetch");
        jmpGo     <= 1'b1;
        jmpTarget <= 16'h1000;
        @(posedge ref_clk);
        jmpGo     <= 1'b0;
        agen(CAS_AG_FETCH, 16'h0000, 20'h00FF0);
        for (int i = 0; i < 8; i++) wgpr(3'(i), CAS_WR_WORD, 16'(16'h1111 * (i + 1)));
        for (int i = 0; i < 8; i++) rdchk(8'(4 * i), 32'(16'h1111 * (i + 1)), 1'b0);
        wgpr(3'h0, CAS_WR_LOW, 16'h00AB);
        wgpr(3'h0, CAS_WR_HIGH, 16'h00CD);
        chk(32'(accumulatorWord), 32'hCDAB, "byte halves");
        chk(32'(ioPortReg), 32'h3333, "io port");
        wgpr(3'h3, CAS_WR_HIGH, 16'h0077);
        rdchk(8'h0C, 32'h00007744, 1'b0);
        chk(32'(stackPointer), 32'h5555, "stack pointer");
        wr(8'h04, 32'hFFFF1357);
        chk(32'(countReg), 32'h1357, "count");
        chk(32'(shiftCountByte), 32'h57, "shift count");
        rdchk(8'h04, 32'h00001357, 1'b0);
        seg(CAS_SEG_DATA, 16'h1234);
        agen(CAS_AG_DATA, 16'h5678, 20'h179B8);
        seg(CAS_SEG_EXTRA, 16'hFFFF);
        agen(CAS_AG_EXTRA, 16'h0020, 20'h00010);
        seg(CAS_SEG_STACK, 16'h0100);
        agen(CAS_AG_STACK, 16'hFFFF, 20'h10FFF);
        alu(1'b0, 16'h8000, 1'b1, 1'b1, 1'b0, 1'b0);
        alu(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
        alu(1'b1, 16'h0180, 1'b1, 1'b0, 1'b0, 1'b0);
        alu(1'b1, 16'h0100, 1'b0, 1'b0, 1'b1, 1'b1);
        alu(1'b0, 16'h0007, 1'b1, 1'b0, 1'b0, 1'b0);
        ctl(4'b1000);
        chk(32'(stringStepUp), 32'h1, "step up");
        step(1'b1, 16'h7779, 16'h888A);
        ctl(4'b0100);
        step(1'b0, 16'h7778, 16'h8889);
        maskIntReq <= 1'b1;
        ctl(4'b0010);
        chk(32'(intAccept), 32'h1, "interrupt taken");
        ctl(4'b0001);
        chk(32'(intAccept), 32'h0, "interrupt ignored");
        fload(16'h0100, 1'b1);
        chk(32'(debugTrap), 32'h0, "no trap on load");
        done(1'b1);
        done(1'b1);
        fload(16'h0000, 1'b0);
        done(1'b0);
        fload(16'hFFFF, 1'b0);
        chk(32'(processorStatusFlags), 32'h0FD5, "reserved bits");
        fload(16'h0000, 1'b0);
        wr(`CAS_FLAGS_ADDR, 32'hFFFFFFFF);
        rdchk(`CAS_FLAGS_ADDR, 32'h00000FD5, 1'b0);
        rdchk(8'h34, 32'h0, 1'b1);
        rdchk(8'h02, 32'h0, 1'b1);
        print_verdict();
    end
endmodule // cas_arch_regs_test
